// file: logic/lfsup_pkg.sv
// Constants, state encoding and functional notes of the LED driver fault supervisor.
// Functional notes
// - Input undervoltage: power off, standby, flag, interrupt.
// - Input undervoltage release restarts start-up sequence.
// - Input overvoltage: power off, standby, flag, interrupt.
// - Input overvoltage release restarts start-up sequence.
// - Logic supply low: standby, flag, auto restart.
// - Input overcurrent: fault recovery, flag, 100 ms retry.
// - Cycle current limit never flags or changes state.
// - Charge pump low: fault recovery, flag, 100 ms retry.
// - Pump capacitor fault at init: both flags, recovery.
// - Config integrity error: flag only, keep running.
// - Boost overvolt low: flag, stop switching, no recovery.
// - Overvolt low checked only in soft-start or run.
// - Boost overvolt high: flag, interrupt, 100 ms recovery.
// - Overvolt high checked only in soft-start or run.
// - Feedback low for 110 ms: overcurrent flag, recovery.
// - Overcurrent timer runs from boost start.
// - Flags grouped into supply and boost registers; string register reads zero.
// - All timing derived from the single system clock.
package lfsup_pkg;

    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned RESTART_MS   = 100;
    localparam int unsigned OCP_QUAL_MS  = 110;
    localparam int unsigned RESTART_CYC  = CLK_HZ / 1000 * RESTART_MS;
    localparam int unsigned OCP_QUAL_CYC = CLK_HZ / 1000 * OCP_QUAL_MS;
    localparam int unsigned TMR_W        = 22;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned FLAG_W = 16;

    localparam logic [7:0] OFS_SUPPLY_STAT = 8'h00;
    localparam logic [7:0] OFS_BOOST_STAT  = 8'h01;
    localparam logic [7:0] OFS_STRING_STAT = 8'h02;
    localparam logic [7:0] OFS_FLAG_CLR    = 8'h03;
    localparam logic [7:0] OFS_FLAG_EN     = 8'h04;
    localparam logic [7:0] OFS_CTRL        = 8'h05;
    localparam logic [7:0] OFS_STATE       = 8'h06;

    localparam int unsigned F_IN_UV    = 0;
    localparam int unsigned F_IN_OV    = 1;
    localparam int unsigned F_VDD_LOW  = 2;
    localparam int unsigned F_IN_OC    = 3;
    localparam int unsigned F_PUMP_LOW = 4;
    localparam int unsigned F_PUMP_CAP = 5;
    localparam int unsigned F_CFG_CRC  = 6;
    localparam int unsigned F_BST_OVL  = 8;
    localparam int unsigned F_BST_OVH  = 9;
    localparam int unsigned F_BST_OCP  = 10;

    localparam logic [15:0] FLAG_VALID   = 16'h077F;
    localparam logic [15:0] FLAG_EN_RST  = 16'h077F;
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam logic        CTRL_RUN_RST = 1'b1;

    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_INIT  = 3'h1,
        ST_SOFT  = 3'h2,
        ST_RUN   = 3'h3,
        ST_STBY  = 3'h4,
        ST_RECOV = 3'h5
    } lfsup_state_t;

endpackage : lfsup_pkg

// file: logic/lfsup_timer.sv
// Qualification and restart timer that expires after a run of COUNT enabled cycles.
`timescale 1ns/100ps
`default_nettype none
module lfsup_timer #(
    parameter int unsigned W     = 22,
    parameter logic [W-1:0] COUNT = 1
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic run,
    output logic      expired
);
    typedef struct packed {
        logic [W-1:0] count;
    } lfsup_tmr_t;

    lfsup_tmr_t tmr_reg;
    lfsup_tmr_t tmr_next;

    // Dropping run reloads the count, so only an unbroken run can expire.
    always_comb begin
        tmr_next = tmr_reg;
        if (!run) begin
            tmr_next.count = COUNT - W'(1);
        end else if (tmr_reg.count != '0) begin
            tmr_next.count = tmr_reg.count - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tmr_reg.count <= COUNT - W'(1);
        end else if (ce) begin
            tmr_reg <= tmr_next;
        end
    end

    assign expired = run && (tmr_reg.count == '0);

endmodule : lfsup_timer
`default_nettype wire

// file: logic/lfsup_flags.sv
// Sticky fault flags with write-one clear, enable mask and level interrupt.
`timescale 1ns/100ps
`default_nettype none
module lfsup_flags #(
    parameter int unsigned W      = 16,
    parameter logic [W-1:0] VALID  = '1,
    parameter logic [W-1:0] EN_RST = '1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic [W-1:0] set,
    input  wire logic         clr_we,
    input  wire logic         en_we,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] flags,
    output logic      [W-1:0] en,
    output logic              irq
);
    typedef struct packed {
        logic [W-1:0] flags;
        logic [W-1:0] en;
    } lfsup_flg_t;

    lfsup_flg_t flg_reg;
    lfsup_flg_t flg_next;

    always_comb begin
        flg_next = flg_reg;
        flg_next.flags = (flg_reg.flags & ~(clr_we ? wdata : '0)) | (set & VALID);
        if (en_we) begin
            flg_next.en = wdata & VALID;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            flg_reg.flags <= '0;
            flg_reg.en    <= EN_RST;
        end else if (ce) begin
            flg_reg <= flg_next;
        end
    end

    assign flags = flg_reg.flags;
    assign en    = flg_reg.en;
    assign irq   = |(flg_reg.flags & flg_reg.en);

endmodule : lfsup_flags
`default_nettype wire

// file: logic/lfsup_top.sv
// Fault supervisor: state sequencing, power stage enables, register port and interrupt.
`timescale 1ns/100ps
`default_nettype none
module lfsup_top
    import lfsup_pkg::*;
#(
    parameter logic [TMR_W-1:0] RESTART_CYCLES  = TMR_W'(RESTART_CYC),
    parameter logic [TMR_W-1:0] OCP_QUAL_CYCLES = TMR_W'(OCP_QUAL_CYC)
) (
    input  wire logic              CLK_SYS,
    input  wire logic              SRST,
    input  wire logic              CE,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [DATA_W-1:0] RDATA,
    input  wire logic              INPUT_UNDERVOLT,
    input  wire logic              INPUT_OVERVOLT,
    input  wire logic              LOGIC_SUPPLY_LOW,
    input  wire logic              INPUT_OVERCURRENT,
    input  wire logic              PUMP_LOW,
    input  wire logic              PUMP_CAP_FAULT,
    input  wire logic              CONFIG_CRC_FAIL,
    input  wire logic              INIT_DONE,
    input  wire logic              SOFTSTART_DONE,
    input  wire logic              FB_OVERVOLT_LOW,
    input  wire logic              FB_OVERVOLT_HIGH,
    input  wire logic              BLEED_OVERVOLT_HIGH,
    input  wire logic              FB_UNDERVOLT,
    input  wire logic              CYCLE_CURRENT_LIMIT,
    output logic                   BOOST_EN,
    output logic                   BOOST_GATE_EN,
    output logic                   LED_EN,
    output logic                   LINE_SWITCH_EN,
    output logic                   PUMP_EN,
    output logic [2:0]             STATE,
    output logic                   INT
);
    typedef struct packed {
        lfsup_state_t      state;
        logic              ctrl_run;
        logic [DATA_W-1:0] rdata;
    } lfsup_main_t;

    lfsup_main_t main_reg;
    lfsup_main_t main_next;

    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] flag_en;
    logic              clr_we;
    logic              en_we;
    logic              op;
    logic              boost_phase;
    logic              standby_fault;
    logic              recov_fault;
    logic              cap_fault_now;
    logic              ocp_run;
    logic              ocp_expired;
    logic              restart_expired;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction : hit

    assign op          = (main_reg.state == ST_INIT) || (main_reg.state == ST_SOFT) ||
                         (main_reg.state == ST_RUN);
    assign boost_phase = (main_reg.state == ST_SOFT) || (main_reg.state == ST_RUN);
    assign clr_we      = WR && hit(ADDR, OFS_FLAG_CLR);
    assign en_we       = WR && hit(ADDR, OFS_FLAG_EN);

    assign ocp_run = boost_phase && FB_UNDERVOLT;

    lfsup_timer #(
        .W     (TMR_W),
        .COUNT (OCP_QUAL_CYCLES)
    ) u_ocp_timer (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .ce      (CE),
        .run     (ocp_run),
        .expired (ocp_expired)
    );

    lfsup_timer #(
        .W     (TMR_W),
        .COUNT (RESTART_CYCLES)
    ) u_restart_timer (
        .clk     (CLK_SYS),
        .srst    (SRST),
        .ce      (CE),
        .run     (main_reg.state == ST_RECOV),
        .expired (restart_expired)
    );

    assign cap_fault_now = (main_reg.state == ST_INIT) && INIT_DONE && PUMP_CAP_FAULT;

    // Supply faults send the device to standby.
    assign standby_fault = INPUT_UNDERVOLT || INPUT_OVERVOLT || LOGIC_SUPPLY_LOW;

    // Faults that need a timed retry.
    assign recov_fault = INPUT_OVERCURRENT || PUMP_LOW || cap_fault_now ||
                         (boost_phase && (FB_OVERVOLT_HIGH || BLEED_OVERVOLT_HIGH || ocp_expired));

    always_comb begin
        flag_set = '0;
        if (op) begin
            flag_set[F_IN_UV]    = INPUT_UNDERVOLT;
            flag_set[F_IN_OV]    = INPUT_OVERVOLT;
            flag_set[F_VDD_LOW]  = LOGIC_SUPPLY_LOW;
            flag_set[F_IN_OC]    = INPUT_OVERCURRENT;
            flag_set[F_PUMP_LOW] = PUMP_LOW;
        end
        if ((main_reg.state == ST_INIT) && INIT_DONE) begin
            // Both pump flags on capacitor fault.
            if (PUMP_CAP_FAULT) begin
                flag_set[F_PUMP_CAP] = 1'b1;
                flag_set[F_PUMP_LOW] = 1'b1;
            end
            flag_set[F_CFG_CRC] = CONFIG_CRC_FAIL;
        end
        if (boost_phase) begin
            flag_set[F_BST_OVL] = FB_OVERVOLT_LOW;
            flag_set[F_BST_OVH] = FB_OVERVOLT_HIGH || BLEED_OVERVOLT_HIGH;
            flag_set[F_BST_OCP] = ocp_expired;
        end
    end

    // Two flag groups, supply and boost, behind one bank.
    lfsup_flags #(
        .W      (FLAG_W),
        .VALID  (FLAG_VALID),
        .EN_RST (FLAG_EN_RST)
    ) u_flags (
        .clk    (CLK_SYS),
        .srst   (SRST),
        .ce     (CE),
        .set    (flag_set),
        .clr_we (clr_we),
        .en_we  (en_we),
        .wdata  (FLAG_W'(WDATA)),
        .flags  (flags),
        .en     (flag_en),
        .irq    (INT)
    );

    always_comb begin
        main_next       = main_reg;
        main_next.rdata = '0;
        if (WR && hit(ADDR, OFS_CTRL)) begin
            main_next.ctrl_run = WDATA[CTRL_RUN_BIT];
        end
        if (RD) begin
            if (hit(ADDR, OFS_SUPPLY_STAT)) begin
                main_next.rdata = DATA_W'(flags[7:0]);
            end else if (hit(ADDR, OFS_BOOST_STAT)) begin
                main_next.rdata = DATA_W'(flags[15:8]);
            end else if (hit(ADDR, OFS_FLAG_EN)) begin
                main_next.rdata = DATA_W'(flag_en);
            end else if (hit(ADDR, OFS_CTRL)) begin
                main_next.rdata = DATA_W'(main_reg.ctrl_run);
            end else if (hit(ADDR, OFS_STATE)) begin
                main_next.rdata = DATA_W'(main_reg.state);
            end
        end
        // Cycle current limit is not a state input.
        case (main_reg.state)
            ST_OFF: begin
                main_next.state = ST_STBY;
            end
            ST_STBY: begin
                if (!standby_fault) begin
                    main_next.state = ST_INIT;
                end
            end
            ST_INIT, ST_SOFT, ST_RUN: begin
                // Standby faults take priority since supplies gone make a retry pointless.
                if (standby_fault) begin
                    main_next.state = ST_STBY;
                end else if (recov_fault) begin
                    main_next.state = ST_RECOV;
                end else if ((main_reg.state == ST_INIT) && INIT_DONE) begin
                    main_next.state = ST_SOFT;
                end else if ((main_reg.state == ST_SOFT) && SOFTSTART_DONE) begin
                    main_next.state = ST_RUN;
                end
            end
            ST_RECOV: begin
                if (restart_expired) begin
                    main_next.state = ST_INIT;
                end
            end
            default: begin
                main_next.state = ST_OFF;
            end
        endcase
        if (!main_reg.ctrl_run) begin
            main_next.state = ST_OFF;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            main_reg.state    <= ST_OFF;
            main_reg.ctrl_run <= CTRL_RUN_RST;
            main_reg.rdata    <= '0;
        end else if (CE) begin
            main_reg <= main_next;
        end
    end

    assign RDATA          = main_reg.rdata;
    assign STATE          = main_reg.state;
    assign PUMP_EN        = op;
    assign LINE_SWITCH_EN = op;
    assign BOOST_EN       = boost_phase;
    assign LED_EN         = boost_phase;
    assign BOOST_GATE_EN  = boost_phase && !FB_OVERVOLT_LOW && !CYCLE_CURRENT_LIMIT;

    property p_in_uv;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && op && main_reg.ctrl_run && INPUT_UNDERVOLT
        |=> main_reg.state == ST_STBY && flags[F_IN_UV] && (INT || !flag_en[F_IN_UV]);
    endproperty
    a_in_uv: assert property (p_in_uv) else $error("undervoltage did not reach standby");

    property p_in_ov;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && op && main_reg.ctrl_run && INPUT_OVERVOLT
        |=> main_reg.state == ST_STBY && flags[F_IN_OV] && !BOOST_EN && !LED_EN;
    endproperty
    a_in_ov: assert property (p_in_ov) else $error("overvoltage did not reach standby");

    property p_stby_exit;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && main_reg.state == ST_STBY && main_reg.ctrl_run && !standby_fault
        |=> main_reg.state == ST_INIT && PUMP_EN;
    endproperty
    a_stby_exit: assert property (p_stby_exit) else $error("standby not left");

    property p_in_oc;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && op && main_reg.ctrl_run && !standby_fault && INPUT_OVERCURRENT
        |=> main_reg.state == ST_RECOV && flags[F_IN_OC] && !LINE_SWITCH_EN;
    endproperty
    a_in_oc: assert property (p_in_oc) else $error("overcurrent did not start recovery");

    property p_cycle_limit;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && main_reg.state == ST_RUN && main_reg.ctrl_run && CYCLE_CURRENT_LIMIT &&
        !standby_fault && !recov_fault && flag_set == '0
        |-> !BOOST_GATE_EN ##1 main_reg.state == ST_RUN;
    endproperty
    a_cycle_limit: assert property (p_cycle_limit) else $error("current limit changed state");

    property p_ovl;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && main_reg.state == ST_RUN && main_reg.ctrl_run && FB_OVERVOLT_LOW &&
        !standby_fault && !recov_fault
        |-> !BOOST_GATE_EN ##1 main_reg.state == ST_RUN && flags[F_BST_OVL];
    endproperty
    a_ovl: assert property (p_ovl) else $error("overvolt low mishandled");

    property p_ovl_ignored;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && !boost_phase && !flags[F_BST_OVL] |=> !flags[F_BST_OVL];
    endproperty
    a_ovl_ignored: assert property (p_ovl_ignored) else $error("overvolt low flagged off phase");

    property p_ovh;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && boost_phase && main_reg.ctrl_run && !standby_fault && BLEED_OVERVOLT_HIGH
        |=> main_reg.state == ST_RECOV && flags[F_BST_OVH];
    endproperty
    a_ovh: assert property (p_ovh) else $error("overvolt high did not start recovery");

    property p_ocp;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && boost_phase && main_reg.ctrl_run && !standby_fault && ocp_expired
        |=> main_reg.state == ST_RECOV && flags[F_BST_OCP];
    endproperty
    a_ocp: assert property (p_ocp) else $error("boost overcurrent missed");

    property p_cap;
        @(posedge CLK_SYS) disable iff (SRST)
        CE && main_reg.ctrl_run && !standby_fault && cap_fault_now
        |=> main_reg.state == ST_RECOV && flags[F_PUMP_CAP] && flags[F_PUMP_LOW] && !PUMP_EN;
    endproperty
    a_cap: assert property (p_cap) else $error("pump capacitor fault mishandled");

    property p_irq;
        @(posedge CLK_SYS) disable iff (SRST)
        (flags & flag_en) != '0 |-> INT;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt low with enabled flag");

endmodule : lfsup_top
`default_nettype wire

// file: sim/lfsup_host.sv
// Host model: register port master that reads status and clears flags.
`timescale 1ns/100ps
`default_nettype none
module lfsup_host
    import lfsup_pkg::*;
(
    input  wire logic              clk,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] wdata,
    output logic                   wr,
    output logic                   rd,
    input  wire logic [DATA_W-1:0] rdata
);
    initial begin
        addr  = '0;
        wdata = '0;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    task automatic put(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
        #1;
    endtask : put
    // Released address is inverted so a stale value cannot pass.
    task automatic get(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask : get
endmodule : lfsup_host
`default_nettype wire

// file: sim/lfsup_tb_top.sv
// Self-checking bench of the fault supervisor against scripted expected state, flags and outputs.
`timescale 1ns/100ps
`default_nettype none
module lfsup_tb_top
    import lfsup_pkg::*;
;
    localparam int RST_CYC = 20;
    localparam int OCP_CYC = 30;
    logic              clk;
    logic              srst;
    logic              ce;
    logic [13:0]       fin;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              wr;
    logic              rd;
    logic              gate;
    logic              boost;
    logic              led;
    logic              lsw;
    logic              pump;
    logic [2:0]        state;
    logic              irq;
    int                mismatches = 0;
    int                check_count = 0;
    int                cyc = 0;
    int                n;
    logic [2:0]        exp_st;
    logic [15:0]       exp_flags;
    logic [15:0]       exp_en;
    logic [15:0]       r;
    int                rec_idx [4] = '{3, 4, 10, 11};
    int                rec_bit [4] = '{3, 4, 9, 9};

    lfsup_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    lfsup_top #(
        .RESTART_CYCLES(TMR_W'(RST_CYC)),
        .OCP_QUAL_CYCLES(TMR_W'(OCP_CYC))
    ) DUT (
        .CLK_SYS(clk),
        .SRST(srst),
        .CE(ce),
        .ADDR(addr),
        .WDATA(wdata),
        .WR(wr),
        .RD(rd),
        .RDATA(rdata),
        .INPUT_UNDERVOLT(fin[0]),
        .INPUT_OVERVOLT(fin[1]),
        .LOGIC_SUPPLY_LOW(fin[2]),
        .INPUT_OVERCURRENT(fin[3]),
        .PUMP_LOW(fin[4]),
        .PUMP_CAP_FAULT(fin[5]),
        .CONFIG_CRC_FAIL(fin[6]),
        .INIT_DONE(fin[7]),
        .SOFTSTART_DONE(fin[8]),
        .FB_OVERVOLT_LOW(fin[9]),
        .FB_OVERVOLT_HIGH(fin[10]),
        .BLEED_OVERVOLT_HIGH(fin[11]),
        .FB_UNDERVOLT(fin[12]),
        .CYCLE_CURRENT_LIMIT(fin[13]),
        .BOOST_EN(boost),
        .BOOST_GATE_EN(gate),
        .LED_EN(led),
        .LINE_SWITCH_EN(lsw),
        .PUMP_EN(pump),
        .STATE(state),
        .INT(irq)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // A hang is cut short well above the expected run length.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_out();
        logic on;
        logic pw;
        on = exp_st == ST_SOFT || exp_st == ST_RUN;
        pw = on || exp_st == ST_INIT;
        chk({8'h00, state, boost, led, lsw, pump, irq},
            {8'h00, exp_st, on, on, pw, pw, |(exp_flags & exp_en)});
    endtask : chk_out

    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.get(a, d);
        chk(d, e);
    endtask : chk_rd

    task automatic chk_flags();
        chk_rd(OFS_SUPPLY_STAT, {8'h00, exp_flags[7:0]});
        chk_rd(OFS_BOOST_STAT, {8'h00, exp_flags[15:8]});
        chk_out();
    endtask : chk_flags

    task automatic clr(input logic [15:0] m);
        host.put(OFS_FLAG_CLR, m);
        exp_flags = exp_flags & ~m;
        chk_out();
    endtask : clr

    task automatic wait_st(input logic [2:0] s, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (state !== s && n < lim);
        exp_st = s;
        chk_out();
    endtask : wait_st

    task automatic pulse(input int i);
        @(posedge clk);
        fin[i] <= 1'b1;
        @(posedge clk);
        fin[i] <= 1'b0;
        #1;
    endtask : pulse

    initial begin
        ce        = 1'b1;
        srst      = 1'b1;
        fin       = 14'h0100;
        exp_st    = ST_OFF;
        exp_flags = '0;
        exp_en    = FLAG_EN_RST;
        r         = 16'($urandom(32'hF1D6));
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        #1 chk_out();
        chk_rd(OFS_FLAG_EN, 16'h077F);
        chk_rd(OFS_CTRL, 16'h0001);
        chk_rd(OFS_FLAG_CLR, 16'h0000);
        chk_rd(OFS_STRING_STAT, 16'h0000);
        chk_rd(8'($urandom_range(255, 7)), 16'h0000);
        host.put(8'($urandom_range(255, 7)), 16'($urandom));
        chk_rd(OFS_FLAG_EN, 16'h077F);
        wait_st(ST_INIT, 20);
        @(posedge clk);
        fin[11:9] <= 3'b111;
        @(posedge clk);
        fin[11:9] <= 3'b000;
        #1 chk_flags();
        @(posedge clk);
        fin[7:6] <= 2'b11;
        exp_flags[F_CFG_CRC] = 1'b1;
        wait_st(ST_SOFT, 3);
        @(posedge clk);
        fin[6] <= 1'b0;
        wait_st(ST_RUN, 3);
        chk_flags();
        clr(16'h0040);
        $display("end of init test");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            fin[i] <= 1'b1;
            @(posedge clk);
            #1 exp_st = ST_STBY;
            exp_flags[i] = 1'b1;
            chk_out();
            repeat (1 + $urandom_range(6)) @(posedge clk);
            fin[i] <= 1'b0;
            wait_st(ST_INIT, 4);
            wait_st(ST_RUN, 4);
            chk_flags();
            clr(16'h0001 << i);
        end
        $display("end of standby test");
        for (int i = 0; i < 4; i++) begin
            pulse(rec_idx[i]);
            exp_st = ST_RECOV;
            exp_flags[rec_bit[i]] = 1'b1;
            chk_out();
            wait_st(ST_INIT, RST_CYC + 8);
            chk(16'(n >= RST_CYC && n <= RST_CYC + 3), 16'h0001);
            wait_st(ST_RUN, 4);
            chk_flags();
            clr(16'hFFFF);
        end
        $display("end of recovery test");
        @(posedge clk);
        fin[9] <= 1'b1;
        @(posedge clk);
        #1 chk(16'(gate), 16'h0000);
        exp_flags[F_BST_OVL] = 1'b1;
        chk_out();
        @(posedge clk);
        fin[9]  <= 1'b0;
        fin[13] <= 1'b1;
        @(posedge clk);
        #1 chk(16'(gate), 16'h0000);
        chk_flags();
        @(posedge clk);
        fin[13] <= 1'b0;
        @(posedge clk);
        #1 chk(16'(gate), 16'h0001);
        clr(16'h0100);
        $display("end of gating test");
        @(posedge clk);
        fin[12] <= 1'b1;
        repeat (OCP_CYC - 5) @(posedge clk);
        fin[12] <= 1'b0;
        #1 chk_out();
        @(posedge clk);
        fin[12] <= 1'b1;
        fin[5]  <= 1'b1;
        exp_flags[F_BST_OCP] = 1'b1;
        wait_st(ST_RECOV, OCP_CYC + 3);
        chk(16'(n >= OCP_CYC - 1), 16'h0001);
        wait_st(ST_INIT, RST_CYC + 4);
        exp_flags[5:4] = 2'b11;
        wait_st(ST_RECOV, 3);
        @(posedge clk);
        fin[5] <= 1'b0;
        fin[8] <= 1'b0;
        wait_st(ST_SOFT, RST_CYC + 6);
        wait_st(ST_RECOV, OCP_CYC + 3);
        @(posedge clk);
        fin[12] <= 1'b0;
        fin[8]  <= 1'b1;
        wait_st(ST_RUN, RST_CYC + 8);
        chk_flags();
        clr(16'hFFFF);
        $display("end of timer test");
        // Enable mask gates only the interrupt.
        host.put(OFS_FLAG_EN, 16'h0000);
        exp_en = '0;
        pulse(3);
        exp_st = ST_RECOV;
        exp_flags[F_IN_OC] = 1'b1;
        chk_out();
        host.put(OFS_FLAG_EN, r);
        exp_en = r & FLAG_VALID;
        chk_out();
        chk_rd(OFS_FLAG_EN, r & FLAG_VALID);
        chk_rd(OFS_SUPPLY_STAT, 16'h0008);
        host.put(OFS_FLAG_EN, FLAG_EN_RST);
        exp_en = FLAG_EN_RST;
        wait_st(ST_RUN, RST_CYC + 8);
        clr(16'h0008);
        $display("end of mask test");
        summarize();
    end
endmodule : lfsup_tb_top
`default_nettype wire
